// File: design/mma_access_map.sv
/*
 * Memory access map of an 8-bit controller: scratchpad RAM, aux RAM,
 * external-move routing, external program/data bus and reset hold filter.
 * Assumes the core gives one-cycle request pulses and waits for the ack.
 */
`timescale 1ns/10ps
module mma_access_map
	import mma_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Device pins.
	input wire logic rst_pin,
	input wire logic ext_program_select,
	output logic program_fetch_strobe_n,
	output logic addr_latch_strobe,
	output logic rd_strobe_n,
	output logic wr_strobe_n,
	input wire logic [7:0] low_addr_data_port_in,
	output logic [7:0] low_addr_data_port_out,
	output logic [7:0] low_addr_data_port_oe,
	input wire logic [7:0] high_addr_port_in,
	output logic [7:0] high_addr_port_out,
	output logic [7:0] high_addr_port_oe,
	output logic low_port_pullup_en,
	// Port settings from the core.
	input wire logic [7:0] high_port_latch,
	input wire logic low_pullup_sel,
	// Program fetch.
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	output logic fetch_ack,
	output logic fetch_ext,
	output logic [7:0] fetch_data,
	// Scratchpad access.
	input wire logic sp_req,
	input wire logic sp_we,
	input wire logic sp_indirect,
	input wire logic sp_ptr_b,
	input wire logic [1:0] sp_bank,
	input wire logic [7:0] sp_addr,
	input wire logic [7:0] sp_wdata,
	output logic sp_ack,
	output logic sp_reject,
	output logic [7:0] sp_rdata,
	// External move.
	input wire logic mx_req,
	input wire logic mx_we,
	input wire logic mx_use_data_pointer_pair,
	input wire logic mx_ptr_b,
	input wire logic [1:0] mx_bank,
	input wire logic [15:0] data_pointer_pair,
	input wire logic [7:0] mx_wdata,
	output logic mx_ack,
	output logic mx_aux,
	output logic [7:0] mx_rdata,
	// Special register port.
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic sfr_hit,
	output logic [7:0] sfr_rdata,
	// Status.
	output logic device_reset,
	output logic exec_internal
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0] sp_ram [SP_WORDS]; // Scratchpad RAM.
	logic [7:0] aux_ram [AUX_WORDS]; // Aux RAM.
	logic ext_int; // Filtered select level, high means internal code.
	logic rst_sync; // Filtered reset pin.
	logic [4:0] rst_cnt; // Cycles the reset pin has been high.
	logic [7:0] aux_ram_page_high_reg; // Page register.
	logic [7:0] chip_config_ctrl_reg; // Chip configuration.
	mma_key_st_t key_st; // Unlock sequence state.
	mma_bus_st_t bus_st; // External bus cycle state.
	logic [2:0] ph; // Bus phase, 0..5.
	logic fetch_pend; // Fetch waits for the bus.
	logic [15:0] fetch_addr_reg; // Held fetch address.
	logic mx_pend; // External move waits for the bus.
	logic mx_we_reg; // Held move direction.
	logic [15:0] mx_addr_reg; // Held move address.
	logic [7:0] mx_wdata_reg; // Held move write data.
	logic cyc_fetch; // Current bus cycle is a fetch.
	logic [7:0] sp_ptr_val; // Pointer register contents.
	logic [7:0] sp_eff; // Effective scratchpad address.
	logic sp_direct_bad; // Direct access above the low range.
	logic [7:0] mx_ptr_val; // Byte pointer for moves.
	logic [15:0] mx_addr; // Full move address.
	logic aux_hit; // Move goes to aux RAM.
	logic bus_start; // Bus cycle begins at next edge.
	logic cfg_we; // Config write is accepted.

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	mma_pin_sync #(.INIT(1'b1)) u_sel_sync (
		.clk(clk),
		.rstn(rstn),
		.d(ext_program_select),
		.q(ext_int)
	);

	mma_pin_sync #(.INIT(1'b0)) u_rst_sync (
		.clk(clk),
		.rstn(rstn),
		.d(rst_pin),
		.q(rst_sync)
	);

	// ************************************************************
	// Address decode
	// ************************************************************
	// Pointer registers sit at bank base plus zero or one.
	assign sp_ptr_val = sp_ram[{3'b000, sp_bank, 2'b00, sp_ptr_b}];
	assign sp_eff = sp_indirect ? sp_ptr_val : sp_addr;
	assign sp_direct_bad = !sp_indirect && (sp_addr > SP_DIRECT_TOP);
	assign mx_ptr_val = sp_ram[{3'b000, mx_bank, 2'b00, mx_ptr_b}];
	// Byte pointer moves take their high byte from the page register.
	assign mx_addr = mx_use_data_pointer_pair ? data_pointer_pair : {aux_ram_page_high_reg, mx_ptr_val};
	assign aux_hit = chip_config_ctrl_reg[CFG_AUX_EN_BIT] && (mx_addr <= AUX_TOP);
	assign cfg_we = sfr_wr && (sfr_addr == SFR_CHIP_CFG) && (key_st == KEY_OPEN);
	assign bus_start = (bus_st == BUS_IDLE) && (ph == PH_LAST) && !device_reset
		&& (mx_pend || (fetch_pend && !ext_int));

	// ************************************************************
	// Reset hold filter
	// ************************************************************
	// Reset acts only after the pin has been high long enough.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_cnt <= 5'h00;
			device_reset <= 1'b0;
		end else if (!rst_sync) begin
			rst_cnt <= 5'h00;
			device_reset <= 1'b0;
		end else begin
			if (rst_cnt != RST_CNT_LAST) begin
				rst_cnt <= rst_cnt + 5'h01;
			end
			device_reset <= (rst_cnt == RST_CNT_LAST);
		end
	end

	// Filtered select and pull-up choice are shown as registered levels.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			exec_internal <= 1'b1;
			low_port_pullup_en <= 1'b0;
		end else begin
			exec_internal <= ext_int;
			low_port_pullup_en <= low_pullup_sel;
		end
	end

	// ************************************************************
	// Special registers and key
	// ************************************************************
	// Key walks 87 then 59; any other byte on the way, or 00 once open, locks again.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			key_st <= KEY_LOCKED;
		end else if (device_reset) begin
			key_st <= KEY_LOCKED;
		end else if (sfr_wr && sfr_addr == SFR_CFG_KEY) begin
			case (key_st)
				KEY_LOCKED: key_st <= (sfr_wdata == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
				KEY_HALF: key_st <= (sfr_wdata == KEY_SECOND) ? KEY_OPEN : KEY_LOCKED;
				KEY_OPEN: key_st <= (sfr_wdata == KEY_RELOCK) ? KEY_LOCKED : KEY_OPEN;
				default: key_st <= KEY_LOCKED;
			endcase
		end
	end

	// Page and config registers; config is guarded by the key.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aux_ram_page_high_reg <= RST_AUX_PAGE;
			chip_config_ctrl_reg <= RST_CHIP_CFG;
		end else if (device_reset) begin
			aux_ram_page_high_reg <= RST_AUX_PAGE;
			chip_config_ctrl_reg <= RST_CHIP_CFG;
		end else begin
			if (sfr_wr && sfr_addr == SFR_AUX_PAGE) begin
				aux_ram_page_high_reg <= sfr_wdata;
			end
			if (cfg_we) begin
				chip_config_ctrl_reg <= sfr_wdata;
			end
		end
	end

	// Register reads; the key register reads as zero.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_hit <= 1'b0;
			sfr_rdata <= 8'h00;
		end else begin
			sfr_hit <= (sfr_rd || sfr_wr) && (sfr_addr == SFR_AUX_PAGE
				|| sfr_addr == SFR_CHIP_CFG || sfr_addr == SFR_CFG_KEY);
			case (sfr_addr)
				SFR_AUX_PAGE: sfr_rdata <= aux_ram_page_high_reg;
				SFR_CHIP_CFG: sfr_rdata <= chip_config_ctrl_reg;
				default: sfr_rdata <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Scratchpad RAM
	// ************************************************************
	// Storage has no reset; rejected direct writes never land.
	always_ff @(posedge clk) begin
		if (sp_req && sp_we && !sp_direct_bad) begin
			sp_ram[sp_eff] <= sp_wdata;
		end
	end

	// Answer one cycle after the request.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sp_ack <= 1'b0;
			sp_reject <= 1'b0;
			sp_rdata <= 8'h00;
		end else begin
			sp_ack <= sp_req;
			sp_reject <= sp_req && sp_direct_bad;
			sp_rdata <= sp_direct_bad ? 8'h00 : sp_ram[sp_eff];
		end
	end

	// ************************************************************
	// Aux RAM and move requests
	// ************************************************************
	// Aux writes touch no pin, so they start no external bus cycle.
	always_ff @(posedge clk) begin
		if (mx_req && mx_we && aux_hit) begin
			aux_ram[mx_addr[9:0]] <= mx_wdata;
		end
	end

	// Aux moves answer next cycle; others wait for a bus cycle.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mx_pend <= 1'b0;
			mx_we_reg <= 1'b0;
			mx_addr_reg <= 16'h0000;
			mx_wdata_reg <= 8'h00;
			mx_ack <= 1'b0;
			mx_aux <= 1'b0;
			mx_rdata <= 8'h00;
		end else if (device_reset) begin
			mx_pend <= 1'b0;
			mx_ack <= 1'b0;
		end else begin
			mx_ack <= 1'b0;
			if (mx_req && aux_hit) begin
				mx_ack <= 1'b1;
				mx_aux <= 1'b1;
				mx_rdata <= aux_ram[mx_addr[9:0]];
			end else if (mx_req) begin
				mx_pend <= 1'b1;
				mx_we_reg <= mx_we;
				mx_addr_reg <= mx_addr;
				mx_wdata_reg <= mx_wdata;
			end else if (bus_st == BUS_STRB && ph == PH_SAMPLE && !cyc_fetch) begin
				// Read data is taken while the read strobe still stands.
				mx_rdata <= low_addr_data_port_in;
			end else if (bus_st == BUS_DONE && !cyc_fetch) begin
				mx_pend <= 1'b0;
				mx_ack <= 1'b1;
				mx_aux <= 1'b0;
			end
		end
	end

	// Fetches from internal code are answered next cycle without the bus.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fetch_pend <= 1'b0;
			fetch_addr_reg <= 16'h0000;
			fetch_ack <= 1'b0;
			fetch_ext <= 1'b0;
			fetch_data <= 8'h00;
		end else if (device_reset) begin
			fetch_pend <= 1'b0;
			fetch_ack <= 1'b0;
		end else begin
			fetch_ack <= 1'b0;
			if (fetch_req && ext_int) begin
				fetch_ack <= 1'b1;
				fetch_ext <= 1'b0;
			end else if (fetch_req) begin
				fetch_pend <= 1'b1;
				fetch_addr_reg <= fetch_addr;
			end else if (bus_st == BUS_STRB && ph == PH_SAMPLE && cyc_fetch) begin
				// Code byte is taken while the fetch strobe still stands.
				fetch_data <= low_addr_data_port_in;
			end else if (bus_st == BUS_DONE && cyc_fetch) begin
				fetch_pend <= 1'b0;
				fetch_ack <= 1'b1;
				fetch_ext <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Bus phase and latch strobe
	// ************************************************************
	// Free-running phase; the latch strobe is high in phase 0.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph <= 3'h0;
			addr_latch_strobe <= 1'b0;
		end else begin
			ph <= (ph == PH_LAST) ? 3'h0 : ph + 3'h1;
			addr_latch_strobe <= (ph == PH_LAST);
		end
	end

	// ************************************************************
	// External bus cycle
	// ************************************************************
	// Moves take priority over fetches; a cycle spans phases 0..5.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_st <= BUS_IDLE;
			cyc_fetch <= 1'b0;
			program_fetch_strobe_n <= 1'b1;
			rd_strobe_n <= 1'b1;
			wr_strobe_n <= 1'b1;
			low_addr_data_port_out <= 8'hFF;
			low_addr_data_port_oe <= 8'h00;
			high_addr_port_out <= 8'hFF;
			high_addr_port_oe <= 8'h00;
		end else if (device_reset) begin
			bus_st <= BUS_IDLE;
			program_fetch_strobe_n <= 1'b1;
			rd_strobe_n <= 1'b1;
			wr_strobe_n <= 1'b1;
			low_addr_data_port_oe <= 8'h00;
			high_addr_port_oe <= 8'h00;
		end else begin
			case (bus_st)
				BUS_IDLE: begin
					// Between cycles the high port is a pulled-up port.
					high_addr_port_out <= high_port_latch;
					high_addr_port_oe <= ~high_port_latch;
					if (bus_start) begin
						bus_st <= BUS_ADDR;
						cyc_fetch <= !mx_pend;
						low_addr_data_port_out <= mx_pend ? mx_addr_reg[7:0] : fetch_addr_reg[7:0];
						low_addr_data_port_oe <= 8'hFF;
						high_addr_port_out <= mx_pend ? mx_addr_reg[15:8] : fetch_addr_reg[15:8];
						high_addr_port_oe <= 8'hFF;
					end
				end
				BUS_ADDR: begin
					// Address is latched; switch the low port to data.
					bus_st <= BUS_STRB;
					program_fetch_strobe_n <= !cyc_fetch;
					rd_strobe_n <= cyc_fetch || mx_we_reg;
					wr_strobe_n <= cyc_fetch || !mx_we_reg;
					low_addr_data_port_out <= mx_wdata_reg;
					low_addr_data_port_oe <= (!cyc_fetch && mx_we_reg) ? 8'hFF : 8'h00;
				end
				BUS_STRB: begin
					// Strobes stand until the sample phase.
					if (ph == PH_SAMPLE) begin
						bus_st <= BUS_DONE;
						program_fetch_strobe_n <= 1'b1;
						rd_strobe_n <= 1'b1;
						wr_strobe_n <= 1'b1;
					end
				end
				BUS_DONE: begin
					bus_st <= BUS_IDLE;
					low_addr_data_port_oe <= 8'h00;
				end
				default: bus_st <= BUS_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_ale_period: assert property (@(posedge clk) disable iff (!rstn)
		addr_latch_strobe |-> ##1 !addr_latch_strobe [*5] ##1 addr_latch_strobe)
		else $error("latch strobe period is not six clocks");
	a_program_fetch_strobe_ext_only: assert property (@(posedge clk) disable iff (!rstn)
		!program_fetch_strobe_n |-> bus_st == BUS_STRB && cyc_fetch)
		else $error("fetch strobe outside an external fetch");
	a_int_no_fetch: assert property (@(posedge clk) disable iff (!rstn)
		(bus_st == BUS_ADDR && cyc_fetch) |-> $past(ext_int) == 1'b0)
		else $error("external fetch while internal code selected");
	a_reset_hold: assert property (@(posedge clk) disable iff (!rstn)
		$rose(device_reset) |-> $past(rst_cnt) == RST_CNT_LAST && $past(rst_sync))
		else $error("reset taken before hold time");
	a_low_mux: assert property (@(posedge clk) disable iff (!rstn || device_reset)
		bus_st == BUS_ADDR |-> low_addr_data_port_oe == 8'hFF
		##1 (mx_we_reg && !cyc_fetch) || low_addr_data_port_oe == 8'h00)
		else $error("low port not multiplexed");
	a_high_addr: assert property (@(posedge clk) disable iff (!rstn)
		bus_st == BUS_STRB |-> high_addr_port_oe == 8'hFF && high_addr_port_out
		== (cyc_fetch ? fetch_addr_reg[15:8] : mx_addr_reg[15:8]))
		else $error("high address missing during access");
	a_upper_indirect: assert property (@(posedge clk) disable iff (!rstn)
		(sp_req && !sp_indirect && sp_addr[7]) |=> sp_ack && sp_reject)
		else $error("direct access reached upper scratchpad");
	a_aux_gate: assert property (@(posedge clk) disable iff (!rstn || device_reset)
		(mx_req && !chip_config_ctrl_reg[CFG_AUX_EN_BIT]) |=> !mx_ack && mx_pend)
		else $error("aux RAM reached while disabled");
	a_aux_quiet: assert property (@(posedge clk) disable iff (!rstn || device_reset)
		(mx_req && aux_hit && bus_st == BUS_IDLE && !bus_start) |=> rd_strobe_n
		&& wr_strobe_n && $stable(low_addr_data_port_oe))
		else $error("aux access disturbed the pins");
	a_key_guard: assert property (@(posedge clk) disable iff (!rstn || device_reset)
		$changed(chip_config_ctrl_reg) |-> $past(key_st) == KEY_OPEN)
		else $error("config changed while locked");

endmodule

// File: pkg/mma_pkg.sv
/*
 * Shared constants and types of the memory access map: special register
 * offsets, reset values, key values, address limits, timing counts and
 * state encodings.
 * Assumes a single 100 MHz clock that stands in for the oscillator.
 */
package mma_pkg;

	// ************************************************************
	// Special register offsets and reset values
	// ************************************************************
	localparam logic [7:0] SFR_AUX_PAGE = 8'hA1; // Aux RAM page register.
	localparam logic [7:0] SFR_CHIP_CFG = 8'hBF; // Chip configuration.
	localparam logic [7:0] SFR_CFG_KEY = 8'hF6; // Write key register.
	localparam logic [7:0] RST_AUX_PAGE = 8'h00; // Page after reset.
	localparam logic [7:0] RST_CHIP_CFG = 8'h00; // Config after reset.
	localparam int CFG_AUX_EN_BIT = 4; // Aux RAM enable field.

	// ************************************************************
	// Key sequence values
	// ************************************************************
	localparam logic [7:0] KEY_FIRST = 8'h87; // First unlock byte.
	localparam logic [7:0] KEY_SECOND = 8'h59; // Second unlock byte.
	localparam logic [7:0] KEY_RELOCK = 8'h00; // Byte that relocks.

	// ************************************************************
	// Address limits
	// ************************************************************
	localparam logic [7:0] SP_DIRECT_TOP = 8'h7F; // Last direct location.
	localparam logic [15:0] AUX_TOP = 16'h03FF; // Last aux RAM address.
	localparam int AUX_WORDS = 1024; // Aux RAM depth.
	localparam int SP_WORDS = 256; // Scratchpad depth.

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int OSC_PERIOD_NS = 10; // Oscillator period.
	localparam int MC_OSC = 12; // Oscillator periods per machine cycle.
	localparam int MC_NS = MC_OSC * OSC_PERIOD_NS; // Machine cycle time.
	localparam int RST_HOLD_MC = 2; // Machine cycles of reset hold.
	localparam int RST_HOLD_NS = RST_HOLD_MC * MC_NS; // Least reset hold.
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
	localparam logic [4:0] RST_CNT_LAST = 5'(RST_HOLD_CYC - 1); // Count at release.
	localparam int ALE_DIV = 6; // Latch strobe divider.
	localparam logic [2:0] PH_LAST = 3'(ALE_DIV - 1); // Last bus phase.
	localparam logic [2:0] PH_SAMPLE = 3'h4; // Phase that samples read data.

	// ************************************************************
	// State encodings
	// ************************************************************
	typedef enum logic [3:0] {
		BUS_IDLE = 4'h1,
		BUS_ADDR = 4'h2,
		BUS_STRB = 4'h4,
		BUS_DONE = 4'h8
	} mma_bus_st_t;

	typedef enum logic [2:0] {
		KEY_LOCKED = 3'h1,
		KEY_HALF = 3'h2,
		KEY_OPEN = 3'h4
	} mma_key_st_t;

endpackage

// File: design/mma_pin_sync.sv
/*
 * Three-stage synchroniser for one pin input.
 * Assumes the pin is asynchronous to clk; the output changes only once
 * the second and third stages agree.
 */
`timescale 1ns/10ps
module mma_pin_sync #(
	parameter logic INIT = 1'b0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Pin and filtered level.
	input wire logic d,
	output logic q
);

	logic s1; // First stage, read only by the second.
	logic s2; // Second stage.
	logic s3; // Third stage.

	// ************************************************************
	// Shift chain and agreement filter
	// ************************************************************
	// The filtered level follows only when stages two and three agree.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q <= INIT;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q <= s3;
			end
		end
	end

endmodule

// File: verification/mma_ext_mem.sv
/*
 * Far-side model: address latch, external ROM and data SRAM.
 * Assumes it alone resolves the low port level from both drivers.
 */
`timescale 1ns/10ps
module mma_ext_mem (
	// Clock and strobes.
	input wire logic clk,
	input wire logic addr_latch_strobe,
	input wire logic program_fetch_strobe_n,
	input wire logic rd_strobe_n,
	input wire logic wr_strobe_n,
	input wire logic low_port_pullup_en,
	// Address and data lines.
	input wire logic [7:0] low_addr_data_port_out,
	input wire logic [7:0] low_addr_data_port_oe,
	input wire logic [7:0] high_addr_port_out,
	output logic [7:0] low_addr_data_port_in
);
	logic [7:0] sram [0:65535]; // Data SRAM with a preset pattern.
	logic [7:0] lo_reg = 8'h00; // Latched low address.
	logic [7:0] last_reg = 8'h00; // Last wire level.
	logic [15:0] addr; // Full address.
	logic [7:0] q; // Byte the memory drives.
	initial for (int i = 0; i < 65536; i++) sram[i] = 8'(i) ^ 8'hC3;
	assign addr = {high_addr_port_out, lo_reg};
	assign q = program_fetch_strobe_n ? sram[addr] : addr[7:0] ^ addr[15:8] ^ 8'h5A;
	// Device bits win, then memory under a read strobe, else pull-up or a flipped level.
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			if (low_addr_data_port_oe[b]) low_addr_data_port_in[b] = low_addr_data_port_out[b];
			else if (!(program_fetch_strobe_n && rd_strobe_n)) low_addr_data_port_in[b] = q[b];
			else low_addr_data_port_in[b] = low_port_pullup_en | ~last_reg[b];
		end
	end
	// The latch catches the address; write data is stored while the write strobe is low.
	always @(posedge clk) begin
		last_reg <= low_addr_data_port_in;
		if (addr_latch_strobe && low_addr_data_port_oe == 8'hFF) lo_reg <= low_addr_data_port_out;
		if (!wr_strobe_n && low_addr_data_port_oe == 8'hFF) sram[addr] <= low_addr_data_port_out;
	end
endmodule

// File: verification/tb_mma_access_map.sv
/*
 * Self-checking bench of the memory access map beside the far-side memory model.
 * Assumes the package, the design and the model are compiled before it.
 */
`timescale 1ns/10ps
module tb_mma_access_map import mma_pkg::*; ;
	// Stimulus, all valued at time zero.
	logic clk = 1'b0, rstn = 1'b0, rst_pin = 1'b0, ext_program_select = 1'b1;
	logic low_pullup_sel = 1'b0, fetch_req = 1'b0, sp_req = 1'b0, sp_we = 1'b0;
	logic sp_indirect = 1'b0, sp_ptr_b = 1'b0, mx_req = 1'b0, mx_we = 1'b0, mx_use_data_pointer_pair = 1'b0;
	logic mx_ptr_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic [1:0] sp_bank = 2'h0, mx_bank = 2'h0;
	logic [7:0] sp_addr = 8'h00, sp_wdata = 8'h00, mx_wdata = 8'h00, sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00, high_port_latch = 8'hFF, high_addr_port_in = 8'h00;
	logic [15:0] fetch_addr = 16'h0000, data_pointer_pair = 16'h0000;
	// Design outputs and captured answers.
	logic program_fetch_strobe_n, addr_latch_strobe, rd_strobe_n, wr_strobe_n, low_port_pullup_en;
	logic fetch_ack, fetch_ext, sp_ack, sp_reject, mx_ack, mx_aux, sfr_hit, device_reset;
	logic exec_internal, flag;
	logic [7:0] low_addr_data_port_out, low_addr_data_port_oe, high_addr_port_out;
	logic [7:0] high_addr_port_oe, fetch_data, sp_rdata, mx_rdata, sfr_rdata, rv, hi_seen;
	wire [7:0] low_addr_data_port_in;
	wire [3:0] acks = {sfr_hit, mx_ack, sp_ack | sp_reject, fetch_ack};
	int n_mismatch = 0, total_checks = 0, n_program_fetch_strobe, n_rw, n_oe, n_dr, n;

	mma_access_map mma_access_map_inst (.*);
	mma_ext_mem mma_ext_mem_inst (.*);

	initial forever #5 clk = ~clk;

	// Bus activity as the far side sees it; scenarios clear the counts.
	always @(posedge clk) begin
		n_program_fetch_strobe += (program_fetch_strobe_n === 1'b0);
		n_rw += (rd_strobe_n === 1'b0 || wr_strobe_n === 1'b0);
		n_oe += (low_addr_data_port_oe !== 8'h00);
		n_dr += (device_reset === 1'b1);
		if (!(program_fetch_strobe_n && rd_strobe_n && wr_strobe_n))
			hi_seen = high_addr_port_out & high_addr_port_oe;
	end

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Drops the request pulse and waits, bounded, for answer k.
	task automatic go(input int k);
		@(posedge clk);
		{fetch_req, sp_req, mx_req, sfr_wr, sfr_rd} <= 5'h00;
		#1;
		for (int i = 0; i < 60 && acks[k] !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (acks[k] !== 1'b1) begin
			chk(1'b0, "no answer");
			final_report();
		end
	endtask
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= w; sfr_rd <= ~w; sfr_addr <= a; sfr_wdata <= d;
		go(3);
		rv = sfr_rdata;
	endtask
	task automatic sp(input logic w, ind, pb, input logic [1:0] bk, input logic [7:0] a, d);
		@(posedge clk);
		sp_req <= 1'b1; sp_we <= w; sp_indirect <= ind; sp_ptr_b <= pb;
		sp_bank <= bk; sp_addr <= a; sp_wdata <= d;
		go(1);
		rv = sp_rdata; flag = sp_reject;
	endtask
	task automatic mx(input logic w, dp, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		mx_req <= 1'b1; mx_we <= w; mx_use_data_pointer_pair <= dp; data_pointer_pair <= a; mx_wdata <= d;
		go(2);
		rv = mx_rdata; flag = mx_aux;
	endtask
	task automatic fetch(input logic [15:0] a);
		@(posedge clk);
		fetch_req <= 1'b1; fetch_addr <= a;
		go(0);
		rv = fetch_data; flag = fetch_ext;
	endtask
	task automatic sel(input logic s);
		@(posedge clk);
		ext_program_select <= s;
		repeat (6) @(posedge clk);
	endtask
	task automatic cfg(input logic [7:0] d);
		sfr(1'b1, SFR_CFG_KEY, KEY_FIRST);
		sfr(1'b1, SFR_CFG_KEY, KEY_SECOND);
		sfr(1'b1, SFR_CHIP_CFG, d);
		sfr(1'b1, SFR_CFG_KEY, KEY_RELOCK);
	endtask
	task automatic pin(input int len);
		@(posedge clk);
		n_dr = 0; rst_pin <= 1'b1;
		repeat (len) @(posedge clk);
		rst_pin <= 1'b0;
		repeat (10) @(posedge clk);
	endtask

	task automatic t_reset();
		sfr(1'b0, SFR_AUX_PAGE, 8'h00);
		chk(rv === RST_AUX_PAGE, "page reset");
		sfr(1'b0, SFR_CHIP_CFG, 8'h00);
		chk(rv === RST_CHIP_CFG, "config reset");
		sfr(1'b0, SFR_CFG_KEY, 8'h00);
		chk(rv === 8'h00, "key reads zero");
		sfr(1'b1, SFR_AUX_PAGE, 8'h3C);
		pin(12);
		chk(n_dr == 0, "short pin pulse");
		pin(40);
		chk(n_dr > 0, "long pin pulse");
		sfr(1'b0, SFR_AUX_PAGE, 8'h00);
		chk(rv === RST_AUX_PAGE, "page cleared");
		$display("reset test done");
	endtask
	task automatic t_ale();
		@(posedge clk);
		low_pullup_sel <= 1'b1; n = 0;
		repeat (60) begin
			@(posedge clk);
			#1;
			n += (addr_latch_strobe === 1'b1);
		end
		chk(n == 10, "latch strobe rate");
		chk(low_port_pullup_en === 1'b1, "pull-up on");
		@(posedge clk);
		low_pullup_sel <= 1'b0;
		$display("strobe test done");
	endtask
	task automatic t_fetch();
		logic [15:0] a;
		n_program_fetch_strobe = 0; n_oe = 0;
		fetch(16'h1234);
		chk(flag === 1'b0 && n_program_fetch_strobe == 0 && n_oe == 0, "internal fetch quiet");
		sel(1'b0);
		chk(exec_internal === 1'b0, "select low seen");
		for (int j = 0; j < 2; j++) begin
			a = j ? 16'hFEDC : 16'h1234;
			n_program_fetch_strobe = 0;
			fetch(a);
			chk(flag === 1'b1 && n_program_fetch_strobe > 0, "external fetch strobe");
			chk(rv === (a[7:0] ^ a[15:8] ^ 8'h5A), "external fetch data");
			chk(hi_seen === a[15:8], "high port address");
		end
		$display("fetch test done");
	endtask
	task automatic t_sp();
		sp(1'b1, 1'b0, 1'b0, 2'h0, SP_DIRECT_TOP, 8'hA5);
		sp(1'b0, 1'b0, 1'b0, 2'h0, SP_DIRECT_TOP, 8'h00);
		chk(rv === 8'hA5 && flag === 1'b0, "direct top");
		sp(1'b1, 1'b0, 1'b1, 2'h2, 8'h11, 8'h80);
		sp(1'b1, 1'b1, 1'b1, 2'h2, 8'h00, 8'h5E);
		sp(1'b1, 1'b0, 1'b0, 2'h0, 8'h80, 8'h11);
		chk(flag === 1'b1, "direct upper refused");
		sp(1'b0, 1'b1, 1'b1, 2'h2, 8'h00, 8'h00);
		chk(rv === 8'h5E && flag === 1'b0, "indirect upper");
		$display("scratchpad test done");
	endtask
	task automatic t_key();
		sfr(1'b1, SFR_CHIP_CFG, 8'h10);
		sfr(1'b0, SFR_CHIP_CFG, 8'h00);
		chk(rv === 8'h00, "locked write");
		cfg(8'h10);
		sfr(1'b1, SFR_CHIP_CFG, 8'h00);
		sfr(1'b1, SFR_CFG_KEY, KEY_FIRST);
		sfr(1'b1, SFR_CFG_KEY, 8'h11);
		sfr(1'b1, SFR_CHIP_CFG, 8'h00);
		sfr(1'b0, SFR_CHIP_CFG, 8'h00);
		chk(rv === 8'h10, "open, relock, bad key");
		$display("key test done");
	endtask
	task automatic t_mx();
		logic [15:0] a;
		sel(1'b1);
		for (int j = 0; j < 2; j++) begin
			a = j ? AUX_TOP : 16'h0134;
			n_rw = 0; n_oe = 0;
			mx(1'b1, 1'b1, a, 8'h78 ^ 8'(j));
			mx(1'b0, 1'b1, a, 8'h00);
			chk(rv === (8'h78 ^ 8'(j)) && flag === 1'b1, "aux data");
			chk(n_rw == 0 && n_oe == 0, "aux pins quiet");
		end
		sfr(1'b1, SFR_AUX_PAGE, 8'h01);
		sp(1'b1, 1'b0, 1'b0, 2'h0, 8'h00, 8'h23);
		mx(1'b1, 1'b0, 16'h0000, 8'h55);
		mx(1'b0, 1'b1, 16'h0123, 8'h00);
		chk(rv === 8'h55 && flag === 1'b1, "page and pointer");
		n_rw = 0;
		mx(1'b1, 1'b1, 16'h0400, 8'hAB);
		chk(flag === 1'b0 && n_rw > 0 && hi_seen === 8'h04, "above aux out");
		mx(1'b0, 1'b1, 16'h0400, 8'h00);
		chk(rv === 8'hAB, "external readback");
		cfg(8'h00);
		mx(1'b0, 1'b1, 16'h0134, 8'h00);
		chk(flag === 1'b0 && rv === (8'h34 ^ 8'hC3), "aux off goes out");
		$display("move test done");
	endtask

	// Reset for four cycles, then the scenarios in turn.
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_ale();
		t_fetch();
		t_sp();
		t_key();
		t_mx();
		final_report();
	end
endmodule
